// ---- rtl/sbo_port.sv ----
module sbo_port #(
  parameter logic [7:0] PART_ID = 8'hA5  // Arbitrary identity value
) (
  // System clock domain
  input  wire logic mclk_in,
  input  wire logic sys_rst_in,
  // Serial link, clocked by the host's shift clock
  input  wire logic sclk_in,
  input  wire logic cs_n_in,
  input  wire logic sdio_in,
  output logic      sdio_out,
  output logic      sdio_oe_n_out,
  output logic      serial_out_line_out,
  output logic      serial_out_line_oe_n_out,
  // Status toward the system domain
  output logic      lsb_first_out,
  output logic      update_out
);

  typedef struct packed {
    sbo_pkg::sbo_phase_type phase;
    logic [3:0]             bit_cnt;
    logic [15:0]            instr;
    logic [7:0]             wr_shift;
    logic [7:0]             rd_shift;
    logic                   rw;
    logic [1:0]             len;
    logic [1:0]             bytes_left;
    logic [9:0]             addr;
    logic [7:0]             cfg;
    logic                   upd_toggle;
  } sbo_link_state_type;

  typedef struct packed {
    logic sdio;
    logic sdio_oe_n;
    logic so;
    logic so_oe_n;
  } sbo_drive_state_type;

  typedef struct packed {
    logic rst_hold;
    logic lsb_meta;
    logic lsb_sync;
    logic upd_meta;
    logic upd_sync;
    logic upd_last;
    logic lsb_first;
    logic update;
  } sbo_sys_state_type;

  sbo_link_state_type  lk;
  sbo_link_state_type  next_lk;
  sbo_drive_state_type dr;
  sbo_drive_state_type next_dr;
  sbo_sys_state_type   sy;
  sbo_sys_state_type   next_sy;

  logic       link_rst;
  logic       cs_high_seen;
  logic       lsb_mode;
  logic       restart;
  logic       wr_en;
  logic       do_update;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic [9:0] rd_addr;
  logic [9:0] step_addr;
  logic [15:0] instr_shifted;
  logic [7:0] byte_shifted;
  logic       byte_end;
  logic       last_byte;

  // Buffered and active register images; 0x000 lives in lk.cfg instead
  logic [7:0] buf_mem    [0:sbo_pkg::TOP_ADDR];
  logic [7:0] active_mem [0:sbo_pkg::TOP_ADDR];

  // Link reset comes from a system flop so its release is glitch free
  assign link_rst = sy.rst_hold;
  assign lsb_mode = lk.cfg[sbo_pkg::CFG_LSB_FIRST_BIT];

  // Select raised since the last edge; asynchronous set, cleared by sclk
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      cs_high_seen <= 1'b1;
    end else begin
      cs_high_seen <= 1'b0;
    end
  end

  // Read data source: live config, fixed identity, else buffer or active
  // Bytes never written read back unknown; hosts write before reading
  always_comb begin
    if (rd_addr == sbo_pkg::CFG_ADDR) begin
      rd_byte = lk.cfg;
    end else if (rd_addr == sbo_pkg::PART_ID_ADDR) begin
      rd_byte = PART_ID;
    end else if (buf_mem[sbo_pkg::RDBACK_ADDR][sbo_pkg::RDBACK_ACTIVE_BIT])
    begin
      rd_byte = active_mem[rd_addr];
    end else begin
      rd_byte = buf_mem[rd_addr];
    end
  end

  // Next address: down with wrap to top when MSB-first, up when LSB-first
  always_comb begin
    if (lsb_mode) begin
      step_addr = lk.addr + 10'h001;
    end else if (lk.addr == sbo_pkg::CFG_ADDR) begin
      step_addr = sbo_pkg::TOP_ADDR;
    end else begin
      step_addr = lk.addr - 10'h001;
    end
  end

  // Link frame state, advanced on rising shift clock edges
  always_comb begin
    next_lk = lk;
    wr_en = 1'b0;
    do_update = 1'b0;
    rd_addr = lk.addr;
    // A raised select outside a stall point aborts or ends the frame
    restart = cs_high_seen &&
              ((lk.bit_cnt[2:0] != 3'h0) || (lk.phase == sbo_pkg::PH_DONE) ||
               (lk.phase == sbo_pkg::PH_DATA && lk.len == sbo_pkg::LEN_STREAM));
    if (restart) begin
      next_lk.phase = sbo_pkg::PH_INSTR;
      next_lk.bit_cnt = 4'h0;
    end
    instr_shifted = lsb_mode ? {sdio_in, lk.instr[15:1]}
                             : {lk.instr[14:0], sdio_in};
    byte_shifted = lsb_mode ? {sdio_in, lk.wr_shift[7:1]}
                            : {lk.wr_shift[6:0], sdio_in};
    wr_byte = byte_shifted;  // Taken after the shifter, so it holds this bit
    byte_end = (lk.bit_cnt[2:0] == sbo_pkg::BYTE_LAST_BIT);
    last_byte = ((lk.len != sbo_pkg::LEN_STREAM) && (lk.bytes_left == 2'h0))
                || (lk.addr == sbo_pkg::TOP_ADDR);
    if (!cs_n_in) begin
      unique case (next_lk.phase)
        sbo_pkg::PH_INSTR: begin
          next_lk.instr = instr_shifted;
          next_lk.bit_cnt = next_lk.bit_cnt + 4'h1;
          if (next_lk.bit_cnt == 4'h0) begin
            // Sixteenth bit: decode and load the address generator
            next_lk.rw = instr_shifted[sbo_pkg::INSTR_RW_BIT];
            next_lk.len = instr_shifted[sbo_pkg::INSTR_LEN_HI:
                                        sbo_pkg::INSTR_LEN_LO];
            next_lk.bytes_left = next_lk.len;
            next_lk.addr = instr_shifted[sbo_pkg::INSTR_ADDR_HI:0];
            next_lk.phase = sbo_pkg::PH_DATA;
            rd_addr = next_lk.addr;
            next_lk.rd_shift = rd_byte;
          end
        end
        sbo_pkg::PH_DATA: begin
          next_lk.wr_shift = byte_shifted;
          next_lk.rd_shift = lsb_mode ? {1'b0, lk.rd_shift[7:1]}
                                      : {lk.rd_shift[6:0], 1'b0};
          next_lk.bit_cnt = {1'b0, lk.bit_cnt[2:0] + 3'h1};
          if (byte_end) begin
            wr_en = !lk.rw;
            do_update = !lk.rw && (lk.addr == sbo_pkg::TOP_ADDR) &&
                        byte_shifted[sbo_pkg::UPDATE_BIT];
            if (do_update) begin
              next_lk.upd_toggle = !lk.upd_toggle;
            end
            if (!lk.rw && lk.addr == sbo_pkg::CFG_ADDR) begin
              next_lk.cfg = byte_shifted;
            end
            if (last_byte) begin
              next_lk.phase = sbo_pkg::PH_DONE;
            end else begin
              next_lk.addr = step_addr;
              next_lk.bytes_left = lk.bytes_left - 2'h1;
              rd_addr = step_addr;
              next_lk.rd_shift = rd_byte;
            end
          end
        end
        sbo_pkg::PH_DONE: begin
          next_lk.bit_cnt = 4'h0;  // Extra clocks ignored until select rises
        end
        default: begin
          next_lk.phase = sbo_pkg::PH_INSTR;
        end
      endcase
    end
  end

  always_ff @(posedge sclk_in or posedge link_rst) begin
    if (link_rst) begin
      lk.phase      <= sbo_pkg::PH_INSTR;
      lk.bit_cnt    <= 4'h0;
      lk.instr      <= 16'h0000;
      lk.wr_shift   <= sbo_pkg::ZERO_BYTE;
      lk.rd_shift   <= sbo_pkg::ZERO_BYTE;
      lk.rw         <= 1'b0;
      lk.len        <= sbo_pkg::LEN_ONE;
      lk.bytes_left <= 2'h0;
      lk.addr       <= 10'h000;
      lk.cfg        <= sbo_pkg::CFG_RESET;
      lk.upd_toggle <= 1'b0;
    end else begin
      lk <= next_lk;
    end
  end

  // Register images; the update copies the buffered bytes below TOP_ADDR in one edge, the top byte from wr_byte
  // No reset here: sclk stops outside frames, so a clear could never run
  always_ff @(posedge sclk_in) begin
    if (wr_en && lk.addr != sbo_pkg::CFG_ADDR) begin
      if (lk.addr == sbo_pkg::TOP_ADDR) begin
        buf_mem[lk.addr] <= {wr_byte[7:1], 1'b0};  // Update bit self-clears
      end else begin
        buf_mem[lk.addr] <= wr_byte;
      end
    end
    if (do_update) begin
      for (int i = 0; i < int'(sbo_pkg::TOP_ADDR); i++) begin
        active_mem[i] <= buf_mem[i];
      end
      active_mem[sbo_pkg::TOP_ADDR] <= {wr_byte[7:1], 1'b0};
    end
  end

  // Read bit launch on the falling edge; lines float while select is high
  always_comb begin
    next_dr = dr;
    next_dr.sdio_oe_n = 1'b1;
    next_dr.so_oe_n = 1'b1;
    next_dr.sdio = lsb_mode ? lk.rd_shift[0] : lk.rd_shift[7];
    next_dr.so = next_dr.sdio;
    if (lk.phase == sbo_pkg::PH_DATA && lk.rw) begin
      if (lk.cfg[sbo_pkg::CFG_SDO_ACTIVE_BIT]) begin
        next_dr.so_oe_n = 1'b0;
      end else begin
        next_dr.sdio_oe_n = 1'b0;
      end
    end
  end

  // Select high floats both lines at once, without waiting for an edge
  always_ff @(negedge sclk_in or posedge link_rst or posedge cs_n_in) begin
    if (link_rst || cs_n_in) begin
      dr.sdio      <= 1'b0;
      dr.sdio_oe_n <= 1'b1;
      dr.so        <= 1'b0;
      dr.so_oe_n   <= 1'b1;
    end else begin
      dr <= next_dr;
    end
  end

  // System side: reset source, bit-order level and update event crossings
  always_comb begin
    next_sy = sy;
    next_sy.rst_hold = sys_rst_in;
    next_sy.lsb_meta = lk.cfg[sbo_pkg::CFG_LSB_FIRST_BIT];
    next_sy.lsb_sync = sy.lsb_meta;
    next_sy.upd_meta = lk.upd_toggle;
    next_sy.upd_sync = sy.upd_meta;
    next_sy.upd_last = sy.upd_sync;
    next_sy.lsb_first = sy.lsb_sync;
    next_sy.update = sy.upd_sync ^ sy.upd_last;
  end

  // Link logic sees reset only through rst_hold, a clean flop output
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      sy <= '{rst_hold: 1'b1, default: 1'b0};
    end else begin
      sy <= next_sy;
    end
  end

  // Outputs straight from flops
  assign sdio_out                 = dr.sdio;
  assign sdio_oe_n_out            = dr.sdio_oe_n;
  assign serial_out_line_out      = dr.so;
  assign serial_out_line_oe_n_out = dr.so_oe_n;
  assign lsb_first_out            = sy.lsb_first;
  assign update_out               = sy.update;

endmodule : sbo_port

// ---- rtl/sbo_pkg.sv ----
package sbo_pkg;

  // Register map
  localparam logic [9:0] CFG_ADDR      = 10'h000;
  localparam logic [9:0] PART_ID_ADDR  = 10'h003;
  localparam logic [9:0] RDBACK_ADDR   = 10'h004;
  localparam logic [9:0] TOP_ADDR      = 10'h232;
  localparam logic [7:0] CFG_RESET     = 8'h18;
  localparam logic [7:0] ZERO_BYTE     = 8'h00;

  // Configuration fields (low nibble decodes; high nibble is its mirror)
  localparam int CFG_SDO_ACTIVE_BIT = 0;
  localparam int CFG_LSB_FIRST_BIT  = 1;
  localparam int UPDATE_BIT         = 0;
  localparam int RDBACK_ACTIVE_BIT  = 0;

  // Instruction word fields
  localparam int INSTR_RW_BIT     = 15;
  localparam int INSTR_LEN_HI     = 14;
  localparam int INSTR_LEN_LO     = 13;
  localparam int INSTR_ADDR_HI    = 9;
  localparam logic [3:0] INSTR_LAST_BIT = 4'hF;
  localparam logic [2:0] BYTE_LAST_BIT  = 3'h7;

  // Transfer length codes
  localparam logic [1:0] LEN_ONE    = 2'h0;
  localparam logic [1:0] LEN_STREAM = 2'h3;

  typedef enum logic [1:0] {
    PH_INSTR = 2'b00,
    PH_DATA  = 2'b01,
    PH_DONE  = 2'b10
  } sbo_phase_type;

endpackage : sbo_pkg

// ---- testbench/sbo_port_monitor.sv ----
module sbo_port_monitor (
  // Clocks and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  input wire logic sclk_in,
  // Link pins
  input wire logic cs_n_in,
  input wire logic sdio_in,
  input wire logic sdio_out,
  input wire logic sdio_oe_n_out,
  input wire logic serial_out_line_out,
  input wire logic serial_out_line_oe_n_out,
  // Status
  input wire logic lsb_first_out,
  input wire logic update_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] bit_cnt;

  // Edges since select fell; select high clears it
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) bit_cnt <= 5'h00;
    else if (bit_cnt != 5'h1F) bit_cnt <= bit_cnt + 5'h01;
  end

  rst_out_a: assert property (@(posedge mclk_in)
    sys_rst_in |=> !lsb_first_out && !update_out) else $error("reset out");
  rel_idle_a: assert property (@(posedge mclk_in)
    $fell(sys_rst_in) |-> sdio_oe_n_out && serial_out_line_oe_n_out
    && !lsb_first_out) else $error("release state");
  upd_pulse_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    update_out |=> !update_out [*8]) else $error("update pulse");
  sel_float_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    cs_n_in |-> sdio_oe_n_out && serial_out_line_oe_n_out)
    else $error("driving while idle");
  one_drv_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    sdio_oe_n_out || serial_out_line_oe_n_out)
    else $error("both lines driven");
  lsb_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
    $changed(lsb_first_out) |=> $stable(lsb_first_out))
    else $error("order glitch");
  instr_quiet_a: assert property (@(posedge sclk_in)
    disable iff (sys_rst_in) !cs_n_in && bit_cnt < 5'h10 |->
    sdio_oe_n_out && serial_out_line_oe_n_out) else $error("early drive");
  instr_reload_a: assert property (@(posedge sclk_in)
    disable iff (sys_rst_in) bit_cnt == 5'h00 |-> sdio_oe_n_out)
    else $error("stale frame");
endmodule : sbo_port_monitor

bind sbo_port sbo_port_monitor u_mon (.mclk_in(mclk_in),
  .sys_rst_in(sys_rst_in), .sclk_in(sclk_in), .cs_n_in(cs_n_in),
  .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n_out(sdio_oe_n_out),
  .serial_out_line_out(serial_out_line_out),
  .serial_out_line_oe_n_out(serial_out_line_oe_n_out),
  .lsb_first_out(lsb_first_out), .update_out(update_out));

// ---- testbench/sbo_host_model.sv ----
module sbo_host_model (
  // Lines the host drives
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      line_out,
  // Device answers
  input  wire logic sdio_in,
  input  wire logic sdio_oe_n_in,
  input  wire logic sol_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv, bit_q, last, lsb, uni;

  // Undriven line shows the inverse of its last level
  always_comb begin
    if (!sdio_oe_n_in) line_out = sdio_in;
    else if (drv) line_out = bit_q;
    else line_out = ~last;
  end
  always @(posedge sclk_out) last <= line_out;
  initial begin
    {sclk_out, drv, bit_q, last, lsb, uni} = 6'h00;
    cs_n_out = 1'b1;
  end

  // Clock stays low outside frames; read bit taken at the rise
  task automatic clk_bit(input logic b, input logic d, output logic r);
    drv = d;
    bit_q = b;
    #40 sclk_out = 1'b1;
    r = uni ? sol_in : line_out;
    #40 sclk_out = 1'b0;
  endtask : clk_bit

  task automatic xfer(input logic rd, input logic [1:0] len,
    input logic [9:0] adr, input int n, inout logic [7:0] d [4]);
    logic [15:0] w;
    logic r;
    int k;
    w = {rd, len, 3'h0, adr};
    #7 cs_n_out = 1'b0;
    for (k = 0; k < 16; k++) clk_bit(w[lsb ? k : 15-k], 1'b1, r);
    for (k = 0; k < 8*n; k++) begin
      clk_bit(d[k/8][lsb ? k%8 : 7-k%8], !rd, r);
      if (rd) d[k/8][lsb ? k%8 : 7-k%8] = r;
    end
    drv = 1'b0;
    #40 cs_n_out = 1'b1;
    #400;
  endtask : xfer
endmodule : sbo_host_model

// ---- testbench/sbo_port_bench.sv ----
module sbo_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
  logic mclk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic sclk, cs_n, sdi, serial_out_line, sdo_oe_n, sol, sol_oe_n, lsb_first, upd;
  int   miscompares, n_compared, n_upd, cycles;
  logic [7:0] d [4];

  sbo_port #(.PART_ID(8'h3C)) u_dut (.mclk_in(mclk_in), // Arbitrary identity
    .sys_rst_in(sys_rst_in), .sclk_in(sclk), .cs_n_in(cs_n),
    .sdio_in(sdi), .sdio_out(serial_out_line), .sdio_oe_n_out(sdo_oe_n),
    .serial_out_line_out(sol), .serial_out_line_oe_n_out(sol_oe_n),
    .lsb_first_out(lsb_first), .update_out(upd));
  sbo_host_model u_host (.sclk_out(sclk), .cs_n_out(cs_n), .line_out(sdi),
    .sdio_in(serial_out_line), .sdio_oe_n_in(sdo_oe_n), .sol_in(sol));

  initial forever #25 mclk_in = ~mclk_in;
  // Update pulses and hang ceiling
  always @(posedge mclk_in) begin
    n_upd += (upd === 1'b1);
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [9:0] a, input logic [1:0] l, input int n,
    input logic [7:0] v [4]);
    d = v;
    u_host.xfer(1'b0, l, a, n, d);
  endtask : wr

  // Only the first n bytes are compared
  task automatic rdchk(input logic [9:0] a, input logic [1:0] l,
    input int n, input logic [7:0] e [4]);
    int i;
    u_host.xfer(1'b1, l, a, n, d);
    for (i = 0; i < n; i++) `CHK(d[i], e[i])
  endtask : rdchk

  initial begin
    repeat (8) @(negedge mclk_in);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge mclk_in);
    rdchk(sbo_pkg::CFG_ADDR, 2'h0, 1, '{8'h18, 8'h00, 8'h00, 8'h00});
    `CHK(lsb_first, 1'b0)
    rdchk(sbo_pkg::PART_ID_ADDR, 2'h0, 1, '{8'h3C, 0, 0, 0});
    wr(sbo_pkg::RDBACK_ADDR, 2'h0, 1, '{8'h00, 0, 0, 0});
    wr(10'h012, 2'h2, 3, '{8'h11, 8'h22, 8'h33, 8'h00});
    rdchk(10'h012, 2'h2, 3, '{8'h11, 8'h22, 8'h33, 8'h00});
    rdchk(10'h011, 2'h1, 2, '{8'h22, 8'h33, 8'h00, 8'h00});
    wr(sbo_pkg::TOP_ADDR, 2'h0, 1, '{8'h00, 0, 0, 0});
    `CHK(n_upd, 0)
    rdchk(10'h000, 2'h3, 2, '{8'h18, 8'h00, 8'h00, 8'h00});
    wr(sbo_pkg::CFG_ADDR, 2'h0, 1, '{8'h5A, 0, 0, 0});
    u_host.lsb = 1'b1;
    repeat (4) @(negedge mclk_in);
    `CHK(lsb_first, 1'b1)
    wr(10'h020, 2'h2, 3, '{8'hA1, 8'hB2, 8'hC3, 8'h00});
    rdchk(10'h020, 2'h2, 3, '{8'hA1, 8'hB2, 8'hC3, 8'h00});
    wr(10'h230, 2'h3, 4, '{8'h5E, 8'h6F, 8'h01, 8'h00});
    repeat (8) @(negedge mclk_in);
    `CHK(n_upd, 1)
    wr(sbo_pkg::RDBACK_ADDR, 2'h0, 1, '{8'h01, 0, 0, 0});
    wr(10'h020, 2'h0, 1, '{8'h77, 0, 0, 0});
    rdchk(10'h020, 2'h0, 1, '{8'hA1, 0, 0, 0});
    rdchk(10'h231, 2'h0, 1, '{8'h6F, 0, 0, 0});
    wr(sbo_pkg::RDBACK_ADDR, 2'h0, 1, '{8'h00, 0, 0, 0});
    rdchk(10'h020, 2'h0, 1, '{8'h77, 0, 0, 0});
    rdchk(sbo_pkg::CFG_ADDR, 2'h0, 1, '{8'h5A, 0, 0, 0});
    wr(sbo_pkg::CFG_ADDR, 2'h0, 1, '{8'h99, 0, 0, 0});
    u_host.lsb = 1'b0;
    u_host.uni = 1'b1;
    repeat (4) @(negedge mclk_in);
    `CHK(lsb_first, 1'b0)
    rdchk(10'h012, 2'h0, 1, '{8'h11, 0, 0, 0});
    wrap_up();
  end
endmodule : sbo_port_bench
